// ### hdl/acl_pkg.sv
package acl_pkg;

    localparam int          APB_AW             = 12;
    localparam logic [11:0] GAIN_OFS           = 12'h000;
    localparam logic [11:0] CTRL_OFS           = 12'h004;
    localparam logic [11:0] STAT_OFS           = 12'h008;

    localparam logic [7:0]  DISC_INT_RST       = 8'h10;
    localparam logic [7:0]  CONT_PROP_RST      = 8'h10;
    localparam logic [7:0]  CONT_INT_RST       = 8'h10;
    localparam logic [7:0]  MOTOR_CONST_RST    = 8'h19;

    localparam int          DISC_INT_SHIFT     = 7;
    localparam int          CONT_PROP_SHIFT    = 8;
    localparam int          CONT_INT_SHIFT     = 9;
    localparam int          MOTOR_SHIFT        = 5;

    localparam logic [9:0]  ANGLE_MIN          = 10'h115;
    localparam logic [9:0]  ANGLE_MAX          = 10'h3FF;
    localparam int          GATES_PER_BRIDGE   = 6;

    localparam int          SPEED_FULL         = 1000;
    localparam int          STANDSTILL_PERMILLE = 8;
    localparam logic [11:0] STANDSTILL_SPEED   = 12'(SPEED_FULL * STANDSTILL_PERMILLE / 1000);

    localparam int          CLK_PERIOD_NS      = 4;
    localparam int          LOOP_PERIOD_NS     = 1000;
    localparam int          LOOP_CYCLES        = LOOP_PERIOD_NS / CLK_PERIOD_NS;
    localparam int          STANDSTILL_DELAY_NS = 10000;
    localparam int          STANDSTILL_CYCLES  = (STANDSTILL_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef struct packed {
        logic [7:0] motor_const;
        logic [7:0] cont_int;
        logic [7:0] cont_prop;
        logic [7:0] disc_int;
    } gain_set_s;

    typedef struct packed {
        logic series_twelve;
        logic sq_series;
        logic adaptive_dis;
        logic lockout;
        logic direct;
        logic standstill_mode;
        logic standstill_en;
        logic inhibit;
    } ctrl_s;

    localparam ctrl_s CTRL_RST = '{standstill_en: 1'b1, default: 1'b0};

    typedef struct packed {
        logic signed [11:0] demand;
        logic signed [11:0] feedback;
        logic [9:0]         post_ramp_ref;
        logic [11:0]        speed;
        logic               stop_cmd;
        logic               zero_ref;
        logic               discontinuous;
        logic               overcurrent;
    } loop_in_s;

    typedef struct packed {
        logic [GATES_PER_BRIDGE-1:0] normal;
        logic [GATES_PER_BRIDGE-1:0] delayed;
        logic [GATES_PER_BRIDGE-1:0] bridge2;
    } pulse_in_s;

    typedef struct packed {
        logic [17:0] unused;
        logic        stop_fire;
        logic        phase_back;
        logic        series_latched;
        logic        active_bridge;
        logic [9:0]  angle;
    } status_s;

endpackage : acl_pkg

// ### hdl/armature_current_loop_control.sv
// The APB slave port and the register addresses were decided locally.
`timescale 1ns/10ps
module armature_current_loop_control (
    input  wire logic                       core_clk,
    input  wire logic                       rst_b,
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [acl_pkg::APB_AW-1:0] paddr,
    input  wire logic [31:0]                pwdata,
    input  wire logic [3:0]                 pstrb,
    output logic [31:0]                     prdata,
    output logic                            pready,
    output logic                            pslverr,
    input  wire acl_pkg::loop_in_s          loop_in,
    input  wire acl_pkg::pulse_in_s         pulses,
    input  wire logic                       tune_done,
    input  wire acl_pkg::gain_set_s         tune_gains,
    input  wire logic                       cont_tune_valid,
    input  wire acl_pkg::gain_set_s         cont_tune_gains,
    input  wire logic                       cyclic_reset,
    input  wire logic                       drive_enabled,
    input  wire logic [1:0]                 bridge2_quad_en,
    input  wire logic                       bridge_request,
    input  wire logic                       partner_conducting,
    output logic [9:0]                      firing_angle,
    output logic [2*acl_pkg::GATES_PER_BRIDGE-1:0] gate_drive_connector,
    output logic                            active_bridge,
    output logic                            ramp_reset,
    output logic                            limits_active,
    output logic                            series_divert,
    output logic                            standstill_stop
);
    import acl_pkg::*;

    typedef struct packed {
        gain_set_s                       gains;
        ctrl_s                           ctrl;
        logic [9:0]                      angle;
        logic signed [15:0]              integ;
        logic                            active_bridge;
        logic                            series_latched;
        logic                            power_on_pend;
        logic [7:0]                      tick_cnt;
        logic                            pready;
        logic                            pslverr;
        logic [31:0]                     prdata;
        logic [2*GATES_PER_BRIDGE-1:0]   gates;
        logic                            ramp_reset;
        logic                            limits_active;
    } state_s;

    // Starting at the angle floor keeps the output legal before the first loop tick.
    localparam state_s STATE_RST = '{
        gains:         '{motor_const: MOTOR_CONST_RST, cont_int: CONT_INT_RST,
                         cont_prop: CONT_PROP_RST, disc_int: DISC_INT_RST},
        ctrl:          CTRL_RST,
        angle:         ANGLE_MIN,
        power_on_pend: 1'b1,
        limits_active: 1'b1,
        default:       '0
    };

    localparam logic signed [16:0] INTEG_SPAN = 17'(ANGLE_MAX - ANGLE_MIN);

    state_s                q;
    state_s                d;
    logic signed [11:0]    err;
    logic signed [15:0]    disc_int_term;
    logic signed [15:0]    cont_prop_term;
    logic signed [15:0]    cont_int_term;
    logic signed [15:0]    pred_term;
    logic                  disc_mode;
    logic                  arm;
    logic                  phase_back;
    logic                  stop_fire;
    logic                  sample;
    logic                  tick;
    logic                  gains_wr;

    assign err       = loop_in.demand - loop_in.feedback;
    assign disc_mode = loop_in.discontinuous & ~q.ctrl.adaptive_dis;
    assign sample    = q.power_on_pend | (cyclic_reset & ~drive_enabled);
    assign tick      = q.tick_cnt == 8'(LOOP_CYCLES - 1);
    assign gains_wr  = psel & penable & q.pready & pwrite & (paddr == GAIN_OFS);

    gain_scale #(.SHIFT(DISC_INT_SHIFT)) u_disc_int (
        .value (err),
        .gain  (q.gains.disc_int),
        .term  (disc_int_term)
    );
    gain_scale #(.SHIFT(CONT_PROP_SHIFT)) u_cont_prop (
        .value (err),
        .gain  (q.gains.cont_prop),
        .term  (cont_prop_term)
    );
    gain_scale #(.SHIFT(CONT_INT_SHIFT)) u_cont_int (
        .value (err),
        .gain  (q.gains.cont_int),
        .term  (cont_int_term)
    );
    gain_scale #(.SHIFT(MOTOR_SHIFT)) u_predict (
        .value (loop_in.demand),
        .gain  (q.gains.motor_const),
        .term  (pred_term)
    );

    // A creeping motor at zero reference is allowed in mode 1, which is why the reference term is gated.
    assign arm = q.ctrl.standstill_en
               & (loop_in.stop_cmd | (~q.ctrl.standstill_mode & loop_in.zero_ref))
               & (loop_in.speed < STANDSTILL_SPEED);

    standstill_timer u_standstill (
        .core_clk   (core_clk),
        .rst_b      (rst_b),
        .arm        (arm),
        .phase_back (phase_back),
        .stop_fire  (stop_fire)
    );

    always_comb begin
        logic [31:0]        gw;
        logic               mapped;
        logic signed [16:0] integ_sum;
        logic signed [17:0] angle_sum;
        logic               fire_ok;
        status_s            stat;
        gw        = q.gains;
        mapped    = 1'b0;
        integ_sum = '0;
        angle_sum = '0;
        fire_ok   = 1'b0;
        stat      = '0;
        d         = q;

        // Zero-wait slave: pready is raised for the access phase that follows every setup cycle.
        d.pready  = 1'b0;
        d.pslverr = 1'b0;
        mapped    = (paddr == GAIN_OFS) | (paddr == CTRL_OFS) | (paddr == STAT_OFS);
        stat.stop_fire      = stop_fire;
        stat.phase_back     = phase_back;
        stat.series_latched = q.series_latched;
        stat.active_bridge  = q.active_bridge;
        stat.angle          = q.angle;
        if (psel && !penable) begin
            d.pready  = 1'b1;
            d.pslverr = ~mapped;
            d.prdata  = '0;
            if (!pwrite) begin
                if (paddr == GAIN_OFS) begin
                    d.prdata = q.gains;
                end else if (paddr == CTRL_OFS) begin
                    d.prdata = {24'h000000, q.ctrl};
                end else if (paddr == STAT_OFS) begin
                    d.prdata = stat;
                end
            end
        end
        if (psel && penable && q.pready && pwrite && !q.pslverr) begin
            if (paddr == GAIN_OFS) begin
                for (int i = 0; i < 4; i++) begin
                    if (pstrb[i]) begin
                        gw[8*i +: 8] = pwdata[8*i +: 8];
                    end
                end
                d.gains = gain_set_s'(gw);
            end else if (paddr == CTRL_OFS && pstrb[0]) begin
                d.ctrl = ctrl_s'(pwdata[7:0]);
            end
        end

        // Tuning results land after software writes, so a finished tune is never lost to a software write.
        if (cont_tune_valid) begin
            d.gains.disc_int    = cont_tune_gains.disc_int;
            d.gains.cont_prop   = cont_tune_gains.cont_prop;
            d.gains.motor_const = cont_tune_gains.motor_const;
        end
        if (tune_done) begin
            d.gains = tune_gains;
        end

        d.power_on_pend = 1'b0;
        if (sample) begin
            if (|bridge2_quad_en) begin
                d.series_latched = 1'b0;
                d.ctrl.sq_series = 1'b0;
            end else begin
                d.series_latched = d.ctrl.sq_series;
            end
        end

        d.tick_cnt = tick ? 8'h00 : q.tick_cnt + 8'h01;
        if (tick) begin
            integ_sum = 17'(q.integ) + 17'(disc_mode ? disc_int_term : cont_int_term);
            if (integ_sum < 17'sh0) begin
                integ_sum = '0;
            end else if (integ_sum > INTEG_SPAN) begin
                integ_sum = INTEG_SPAN;
            end
            d.integ   = 16'(integ_sum);
            angle_sum = 18'($signed({1'b0, ANGLE_MIN})) + 18'(integ_sum)
                      + 18'(disc_mode ? pred_term : cont_prop_term);
            if (angle_sum < 18'($signed({1'b0, ANGLE_MIN}))) begin
                d.angle = ANGLE_MIN;
            end else if (angle_sum > 18'($signed({1'b0, ANGLE_MAX}))) begin
                d.angle = ANGLE_MAX;
            end else begin
                d.angle = 10'(angle_sum);
            end
            if (q.ctrl.direct) begin
                d.integ = '0;
                d.angle = (loop_in.post_ramp_ref < ANGLE_MIN) ? ANGLE_MIN : loop_in.post_ramp_ref;
            end
        end
        if (q.ctrl.inhibit || phase_back) begin
            d.integ = '0;
            d.angle = ANGLE_MIN;
        end
        d.limits_active = ~q.ctrl.direct;

        // Changing bridges under a conducting partner would short the shared load path.
        if (bridge_request != q.active_bridge && !(q.ctrl.lockout && partner_conducting)) begin
            d.active_bridge = bridge_request;
        end

        // Overcurrent, inhibit and the standstill stop all block firing in every mode, direct mode included.
        fire_ok = ~q.ctrl.inhibit & ~stop_fire & ~loop_in.overcurrent;
        d.gates[GATES_PER_BRIDGE-1:0] = pulses.normal
            & {GATES_PER_BRIDGE{fire_ok & (~q.active_bridge | q.series_latched)}};
        if (q.series_latched) begin
            d.gates[2*GATES_PER_BRIDGE-1:GATES_PER_BRIDGE] = pulses.delayed & {GATES_PER_BRIDGE{fire_ok}};
        end else begin
            d.gates[2*GATES_PER_BRIDGE-1:GATES_PER_BRIDGE] = pulses.bridge2
                & {GATES_PER_BRIDGE{fire_ok & q.active_bridge}};
        end
        d.ramp_reset = q.ctrl.inhibit;
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            q <= STATE_RST;
        end else begin
            q <= d;
        end
    end

    assign prdata               = q.prdata;
    assign pready               = q.pready;
    assign pslverr              = q.pslverr;
    assign firing_angle         = q.angle;
    assign gate_drive_connector = q.gates;
    assign active_bridge        = q.active_bridge;
    assign ramp_reset           = q.ramp_reset;
    assign limits_active        = q.limits_active;
    assign series_divert        = q.series_latched;
    assign standstill_stop      = stop_fire;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    inhibit_gates_a: assert property (q.ctrl.inhibit |=> gate_drive_connector == '0)
        else $error("Gates fired while inhibited.");
    inhibit_ramps_a: assert property (q.ctrl.inhibit |=> ramp_reset && firing_angle == ANGLE_MIN)
        else $error("Ramps not held reset while inhibited.");
    angle_range_a: assert property (firing_angle >= ANGLE_MIN && firing_angle <= ANGLE_MAX)
        else $error("Firing angle out of range.");
    cont_int_hold_a: assert property (cont_tune_valid && !tune_done && !gains_wr |=> $stable(q.gains.cont_int))
        else $error("Continuous tune changed the integral gain.");
    tune_load_a: assert property (tune_done |=> q.gains == $past(tune_gains))
        else $error("Start-up tune result not loaded.");
    bridge_hold_a: assert property (q.ctrl.lockout && partner_conducting |=> $stable(active_bridge))
        else $error("Bridge changed while partner conducted.");
    series_refuse_a: assert property (sample && |bridge2_quad_en |=> !series_divert && !q.ctrl.sq_series)
        else $error("Series selection accepted with bridge 2 enabled.");
    series_hold_a: assert property (!sample |=> $stable(series_divert))
        else $error("Series selection changed outside sampling.");
    direct_angle_a: assert property (tick && q.ctrl.direct && !q.ctrl.inhibit && !phase_back
        && loop_in.post_ramp_ref >= ANGLE_MIN |=> firing_angle == $past(loop_in.post_ramp_ref))
        else $error("Direct mode angle does not follow the reference.");
    delayed_route_a: assert property (series_divert && !q.ctrl.inhibit && !stop_fire && !loop_in.overcurrent
        |=> gate_drive_connector[2*GATES_PER_BRIDGE-1:GATES_PER_BRIDGE] == $past(pulses.delayed))
        else $error("Delayed pulses not routed to upper gate drives.");
    limits_direct_a: assert property (q.ctrl.direct |=> !limits_active)
        else $error("Limits active in direct mode.");
    overcurrent_block_a: assert property (loop_in.overcurrent |=> gate_drive_connector == '0)
        else $error("Gates fired during overcurrent.");
    stop_block_a: assert property (stop_fire |=> gate_drive_connector == '0)
        else $error("Gates fired after standstill stop.");
    phase_back_angle_a: assert property (phase_back |=> firing_angle == ANGLE_MIN)
        else $error("Angle not phased back at standstill.");
    speed_gate_a: assert property (loop_in.speed >= STANDSTILL_SPEED |=> !phase_back)
        else $error("Standstill armed above threshold speed.");
    stop_only_a: assert property (q.ctrl.standstill_mode && !loop_in.stop_cmd |=> !phase_back)
        else $error("Standstill armed without stop in stop-only mode.");
    no_trigger_a: assert property (!loop_in.stop_cmd && !loop_in.zero_ref |=> !phase_back)
        else $error("Standstill armed without a trigger.");
    standstill_off_a: assert property (!q.ctrl.standstill_en |=> !phase_back && !standstill_stop)
        else $error("Standstill acted while disabled.");
    ramp_release_a: assert property (!q.ctrl.inhibit |=> !ramp_reset)
        else $error("Ramps held reset without inhibit.");
    bridge_follow_a: assert property (!(q.ctrl.lockout && partner_conducting)
        |=> active_bridge == $past(bridge_request))
        else $error("Bridge did not follow the request.");
    series_latch_a: assert property (sample && bridge2_quad_en == 2'b00
        |=> series_divert == q.ctrl.sq_series)
        else $error("Series selection not latched.");
    upper_idle_a: assert property (!series_divert && !active_bridge
        |=> gate_drive_connector[2*GATES_PER_BRIDGE-1:GATES_PER_BRIDGE] == '0)
        else $error("Upper drives fired for idle bridge 2.");
    lower_idle_a: assert property (!series_divert && active_bridge
        |=> gate_drive_connector[GATES_PER_BRIDGE-1:0] == '0)
        else $error("Lower drives fired while bridge 2 active.");
    normal_route_a: assert property (series_divert && !q.ctrl.inhibit && !stop_fire && !loop_in.overcurrent
        |=> gate_drive_connector[GATES_PER_BRIDGE-1:0] == $past(pulses.normal))
        else $error("Normal pulses not on lower drives.");
    direct_integ_a: assert property (tick && q.ctrl.direct |=> q.integ == '0)
        else $error("Integrator not cleared in direct mode.");

    tune_cover_c: cover property (tune_done);
    series_cover_c: cover property ($rose(series_divert));
    standstill_cover_c: cover property ($rose(stop_fire));
    direct_cover_c: cover property (tick && q.ctrl.direct);
    lockout_cover_c: cover property (q.ctrl.lockout && partner_conducting && bridge_request != active_bridge);

endmodule : armature_current_loop_control

// ### hdl/gain_scale.sv
`timescale 1ns/10ps
module gain_scale #(
    parameter int SHIFT = 8
) (
    input  wire logic signed [11:0] value,
    input  wire logic [7:0]         gain,
    output logic signed [15:0]      term
);
    import acl_pkg::*;

    logic signed [20:0] product;

    // Truncation toward minus infinity keeps the shift cheap; the loop absorbs the bias.
    assign product = value * $signed({1'b0, gain});
    assign term    = 16'(product >>> SHIFT);

endmodule : gain_scale

// ### hdl/standstill_timer.sv
`timescale 1ns/10ps
module standstill_timer #(
    parameter int DELAY_CYCLES = acl_pkg::STANDSTILL_CYCLES
) (
    input  wire logic core_clk,
    input  wire logic rst_b,
    input  wire logic arm,
    output logic      phase_back,
    output logic      stop_fire
);
    import acl_pkg::*;

    typedef struct packed {
        logic [15:0] cnt;
        logic        phase_back;
        logic        stop_fire;
    } tmr_s;

    tmr_s q;
    tmr_s d;

    always_comb begin
        d = q;
        if (!arm) begin
            d = '0;
        end else begin
            d.phase_back = 1'b1;
            if (q.cnt == 16'(DELAY_CYCLES - 1)) begin
                d.stop_fire = 1'b1;
            end else begin
                d.cnt = q.cnt + 16'h0001;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign phase_back = q.phase_back;
    assign stop_fire  = q.stop_fire;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    phase_back_a: assert property (arm |=> phase_back) else $error("Standstill did not phase back.");
    stop_delay_a: assert property ($rose(stop_fire) |-> q.cnt == 16'(DELAY_CYCLES - 1))
        else $error("Firing stopped before the delay ran out.");

endmodule : standstill_timer

// ### verif/gate_drive_model.sv
`timescale 1ns/10ps
// Twelve gate drives of one or two bridges; each drive remembers that it was fired since the last clear.
// The drives add no filtering, so a single-cycle glitch on a gate line counts as a firing.
module gate_drive_model (
    input  wire logic        core_clk,
    input  wire logic        clear,
    input  wire logic [11:0] gates,
    output logic [11:0]      fired
);
    always_ff @(posedge core_clk) begin
        if (clear) begin
            fired <= 12'h000;
        end else begin
            fired <= fired | gates;
        end
    end
endmodule : gate_drive_model

// ### verif/testbench.sv
`timescale 1ns/10ps
module testbench;
    import acl_pkg::*;
    logic                            core_clk, rst_b, psel, penable, pwrite, pready, pslverr;
    logic [APB_AW-1:0]               paddr;
    logic [31:0]                     pwdata, prdata, rd_q;
    logic                            err_q, tune_done, cont_tune_valid, cyclic_reset, drive_enabled;
    logic                            bridge_request, partner_conducting, active_bridge, ramp_reset;
    logic                            limits_active, series_divert, standstill_stop, clear;
    logic [1:0]                      bridge2_quad_en;
    loop_in_s                        li;
    pulse_in_s                       pl;
    gain_set_s                       tg, ctg;
    logic [9:0]                      firing_angle;
    logic [11:0]                     gates, fired;
    int                              miscompares, total_checks, cycles;
    localparam int                   STB_CONT = 0, STB_TUNE = 1, STB_CYC = 2, STB_CLR = 3;

    armature_current_loop_control dut (.core_clk(core_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .loop_in(li), .pulses(pl), .tune_done(tune_done), .tune_gains(tg),
        .cont_tune_valid(cont_tune_valid), .cont_tune_gains(ctg), .cyclic_reset(cyclic_reset),
        .drive_enabled(drive_enabled), .bridge2_quad_en(bridge2_quad_en), .bridge_request(bridge_request),
        .partner_conducting(partner_conducting), .firing_angle(firing_angle), .gate_drive_connector(gates),
        .active_bridge(active_bridge), .ramp_reset(ramp_reset), .limits_active(limits_active),
        .series_divert(series_divert), .standstill_stop(standstill_stop));

    gate_drive_model drives (.core_clk(core_clk), .clear(clear), .gates(gates), .fired(fired));

    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : wrap_up

    // A hung handshake would otherwise stall the run forever.
    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles > 20000) begin
            miscompares++;
            wrap_up();
        end
    end

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        rd_q = prdata;
        err_q = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // One-cycle strobe on the selected line; bit order matches the STB_ indices.
    task automatic pulse(input int sel);
        @(posedge core_clk);
        {clear, cyclic_reset, tune_done, cont_tune_valid} <= 4'(1 << sel);
        @(posedge core_clk);
        {clear, cyclic_reset, tune_done, cont_tune_valid} <= 4'h0;
        repeat (3) @(posedge core_clk);
    endtask : pulse

    task automatic settle();
        repeat (3) @(posedge core_clk);
    endtask : settle

    initial begin
        {rst_b, psel, penable, pwrite, tune_done, cont_tune_valid, cyclic_reset, drive_enabled} = '0;
        {bridge_request, partner_conducting, bridge2_quad_en, clear, miscompares, total_checks, cycles} = '0;
        paddr = '0;
        pwdata = '0;
        li = '0;
        tg = 32'h55667788;
        ctg = 32'h11223344;
        pl = '{normal: 6'h2A, delayed: 6'h15, bridge2: 6'h33};
        repeat (20) @(posedge core_clk);
        rst_b <= 1'b1;
        apb(1'b0, GAIN_OFS, '0);
        chk("gain reset", rd_q, 32'h19101010);
        apb(1'b0, CTRL_OFS, '0);
        chk("ctrl reset", rd_q, 32'h00000002);
        apb(1'b0, 12'h00C, '0);
        chk("unmapped error", {31'h0, err_q}, 32'h1);
        chk("unmapped data", rd_q, 32'h0);
        apb(1'b1, GAIN_OFS, 32'hA1B2C3D4);
        pulse(STB_CONT);
        apb(1'b0, GAIN_OFS, '0);
        chk("cont tune gains", rd_q, 32'h11B23344);
        pulse(STB_TUNE);
        apb(1'b0, GAIN_OFS, '0);
        chk("startup tune gains", rd_q, 32'h55667788);
        apb(1'b1, CTRL_OFS, 32'h0);
        settle();
        chk("bridge one gates", {20'h0, gates}, 32'h02A);
        bridge_request <= 1'b1;
        settle();
        chk("bridge two gates", {20'h0, gates}, 32'hCC0);
        apb(1'b1, CTRL_OFS, 32'h10);
        partner_conducting <= 1'b1;
        bridge_request <= 1'b0;
        settle();
        chk("lockout holds", {31'h0, active_bridge}, 32'h1);
        partner_conducting <= 1'b0;
        settle();
        chk("lockout release", {31'h0, active_bridge}, 32'h0);
        apb(1'b1, CTRL_OFS, 32'h01);
        settle();
        chk("inhibit gates", {20'h0, gates}, 32'h0);
        chk("inhibit ramps", {31'h0, ramp_reset}, 32'h1);
        apb(1'b1, CTRL_OFS, 32'h00);
        li.overcurrent <= 1'b1;
        settle();
        chk("overcurrent gates", {20'h0, gates}, 32'h0);
        li.overcurrent <= 1'b0;
        apb(1'b1, CTRL_OFS, 32'h08);
        li.post_ramp_ref <= 10'h258;
        repeat (260) @(posedge core_clk);
        chk("direct angle", {22'h0, firing_angle}, 32'h258);
        chk("direct limits", {31'h0, limits_active}, 32'h0);
        li.post_ramp_ref <= ANGLE_MAX;
        repeat (260) @(posedge core_clk);
        chk("full forward", {22'h0, firing_angle}, 32'h3FF);
        apb(1'b1, CTRL_OFS, 32'h02);
        li.zero_ref <= 1'b1;
        li.speed <= 12'h008;
        settle();
        apb(1'b0, STAT_OFS, '0);
        chk("no phase back at limit", (rd_q >> 12) & 32'h3, 32'h0);
        li.speed <= 12'h007;
        settle();
        apb(1'b0, STAT_OFS, '0);
        chk("zero ref phase back", (rd_q >> 12) & 32'h3, 32'h1);
        chk("phased back angle", {22'h0, firing_angle}, 32'h115);
        apb(1'b1, CTRL_OFS, 32'h06);
        settle();
        apb(1'b0, STAT_OFS, '0);
        chk("stop only mode", (rd_q >> 12) & 32'h3, 32'h0);
        apb(1'b1, CTRL_OFS, 32'h02);
        repeat (2510) @(posedge core_clk);
        chk("standstill stop", {31'h0, standstill_stop}, 32'h1);
        chk("standstill gates", {20'h0, gates}, 32'h0);
        li.zero_ref <= 1'b0;
        settle();
        chk("standstill clear", {31'h0, standstill_stop}, 32'h0);
        apb(1'b1, CTRL_OFS, 32'hC0);
        drive_enabled <= 1'b1;
        pulse(STB_CYC);
        chk("enabled no sample", {31'h0, series_divert}, 32'h0);
        drive_enabled <= 1'b0;
        pulse(STB_CYC);
        chk("series latched", {31'h0, series_divert}, 32'h1);
        chk("series gates", {20'h0, gates}, 32'h56A);
        pulse(STB_CLR);
        chk("drives fired", {20'h0, fired}, 32'h56A);
        bridge2_quad_en <= 2'b01;
        pulse(STB_CYC);
        chk("series refused", {31'h0, series_divert}, 32'h0);
        apb(1'b0, CTRL_OFS, '0);
        chk("series bit forced", rd_q, 32'h80);
        apb(1'b1, CTRL_OFS, 32'h00);
        apb(1'b1, GAIN_OFS, 32'h20008000);
        li.demand <= 12'h064;
        li.feedback <= 12'h023;
        li.discontinuous <= 1'b1;
        repeat (260) @(posedge core_clk);
        chk("predicted angle", {22'h0, firing_angle}, 32'h179);
        apb(1'b1, CTRL_OFS, 32'h20);
        repeat (260) @(posedge core_clk);
        chk("proportional angle", {22'h0, firing_angle}, 32'h135);
        wrap_up();
    end
endmodule : testbench
